//--- hdl/psp_pkg.sv
// constants, types and state layout for the protection and status block
`default_nettype none

package psp_pkg;

    // ----------------------------------------------------------------
    // memory map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 9;
    localparam logic [3:0] ADDR_VWIPER0 = 4'h0;
    localparam logic [3:0] ADDR_VWIPER1 = 4'h1;
    localparam logic [3:0] ADDR_NVWIPER0 = 4'h2;
    localparam logic [3:0] ADDR_NVWIPER1 = 4'h3;
    localparam logic [3:0] ADDR_TERM_CONN = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h5;
    localparam logic [3:0] ADDR_GP_FIRST = 4'h6;

    // ----------------------------------------------------------------
    // reset and factory values
    // ----------------------------------------------------------------
    localparam logic [8:0] MID_SCALE_8BIT = 9'h080;
    localparam logic [8:0] MID_SCALE_7BIT = 9'h040;
    localparam logic [8:0] FULL_SCALE_8BIT = 9'h100;
    localparam logic [8:0] FULL_SCALE_7BIT = 9'h080;
    localparam logic [8:0] ZERO_SCALE = 9'h000;
    localparam logic [8:0] WIPER_STEP = 9'h001;
    localparam logic [8:0] GP_FACTORY = 9'h0FF;
    localparam logic [8:0] TERM_CONN_RESET = 9'h1FF;
    localparam logic [3:0] RESERVED_HIGH_BITS = 4'hF;
    localparam logic RESERVED_TERM_CONN_BIT = 1'b1;

    // ----------------------------------------------------------------
    // terminal-connect field positions inside one channel nibble
    // ----------------------------------------------------------------
    localparam int TC_OVERRIDE = 3;
    localparam int TC_TERM_A = 2;
    localparam int TC_WIPER = 1;
    localparam int TC_TERM_B = 0;
    localparam int TC_CHAN_W = 4;

    // ----------------------------------------------------------------
    // command encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] OP_WRITE = 2'h0;
    localparam logic [1:0] OP_INC = 2'h1;
    localparam logic [1:0] OP_DEC = 2'h2;
    localparam logic [1:0] OP_READ = 2'h3;
    localparam logic [1:0] HV_GUARD = 2'h0;
    localparam logic [1:0] HV_LOCK0 = 2'h1;
    localparam logic [1:0] HV_LOCK1 = 2'h2;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int EE_WRITE_TIME_NS = 5000000;
    localparam int EE_WRITE_CYCLES = EE_WRITE_TIME_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 20;

    typedef enum logic [1:0] {
        PSP_IDLE = 2'b01,
        PSP_PROG = 2'b10
    } psp_prog_t;

    typedef struct packed {
        logic [15:0][8:0] nv_mem;
        logic [8:0] vol_w0;
        logic [8:0] vol_w1;
        logic [7:0] term_conn;
        logic [7:0] term_conn_live;
        logic nv_guard;
        logic nv_lock0;
        logic nv_lock1;
        psp_prog_t prog;
        logic [CNT_W-1:0] cnt;
        logic pend_hv;
        logic [3:0] pend_addr;
        logic [8:0] pend_data;
        logic [1:0] pend_sel;
        logic pend_set;
        logic ack;
        logic err;
        logic [8:0] rdata;
        logic [1:0] term_a_en;
        logic [1:0] term_w_en;
        logic [1:0] term_b_en;
        logic [1:0] wiper_to_b;
    } psp_state_t;

endpackage : psp_pkg

`default_nettype wire

//--- hdl/psp_pin_sync.sv
// three-stage synchroniser for one pin input with agreement filter
`default_nettype none

module psp_pin_sync
    import psp_pkg::*;
#(
    parameter logic RST_VAL = 1'b1
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic pin_i,
    output logic level_o
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } psp_sync_t;

    psp_sync_t q;
    psp_sync_t nxt_q;

    // ----------------------------------------------------------------
    // shift and filter
    // ----------------------------------------------------------------
    // s1 only feeds s2; the level moves once s2 and s3 agree
    always_comb begin
        nxt_q = q;
        nxt_q.s1 = pin_i;
        nxt_q.s2 = q.s1;
        nxt_q.s3 = q.s2;
        if (q.s2 == q.s3) begin
            nxt_q.level = q.s3;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q <= '{RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        end else begin
            q <= nxt_q;
        end
    end

    assign level_o = q.level;

endmodule : psp_pin_sync

`default_nettype wire

//--- hdl/psp_protect_status.sv
// memory protection, status word and terminal-connect control of a digital pot
`default_nettype none

module psp_protect_status
    import psp_pkg::*;
#(
    parameter bit RES_8BIT = 1'b1,
    parameter int unsigned EE_CYCLES = EE_WRITE_CYCLES
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic cmd_valid_i,
    input wire logic [1:0] cmd_op_i,
    input wire logic [3:0] cmd_addr_i,
    input wire logic [8:0] cmd_data_i,
    input wire logic cmd_done_i,
    input wire logic hv_valid_i,
    input wire logic [1:0] hv_sel_i,
    input wire logic hv_set_i,
    input wire logic guard_pin_n_i,
    input wire logic shutdown_pin_n_i,
    output logic ack_o,
    output logic err_o,
    output logic [8:0] rdata_o,
    output logic eeprom_write_active_o,
    output logic [8:0] status_o,
    output logic [8:0] wiper0_o,
    output logic [8:0] wiper1_o,
    output logic [1:0] term_a_en_o,
    output logic [1:0] term_w_en_o,
    output logic [1:0] term_b_en_o,
    output logic [1:0] wiper_to_b_o
);

    localparam logic [8:0] MID_SCALE = RES_8BIT ? MID_SCALE_8BIT : MID_SCALE_7BIT;
    localparam logic [8:0] FULL_SCALE = RES_8BIT ? FULL_SCALE_8BIT : FULL_SCALE_7BIT;
    localparam logic [CNT_W-1:0] EE_LAST = CNT_W'(EE_CYCLES - 1);

    psp_state_t q;
    psp_state_t nxt_q;
    logic guard_pin_n;
    logic shutdown_pin_n;

    // ----------------------------------------------------------------
    // reset state
    // ----------------------------------------------------------------
    // factory image of the non-volatile array; a power event loads both
    // volatile wipers with MID_SCALE, as it does the non-volatile wiper words, so both match
    function automatic psp_state_t init_state();
        psp_state_t s;
        s = '0;
        for (int i = 0; i < 16; i++) begin
            s.nv_mem[i] = GP_FACTORY;
        end
        s.nv_mem[ADDR_NVWIPER0] = MID_SCALE;
        s.nv_mem[ADDR_NVWIPER1] = MID_SCALE;
        s.vol_w0 = MID_SCALE;
        s.vol_w1 = MID_SCALE;
        s.term_conn = TERM_CONN_RESET[7:0];
        s.term_conn_live = TERM_CONN_RESET[7:0];
        s.prog = PSP_IDLE;
        s.term_a_en = '1;
        s.term_w_en = '1;
        s.term_b_en = '1;
        return s;
    endfunction : init_state

    // folded to a constant so the asynchronous branch loads fixed values only
    localparam psp_state_t RST_STATE = init_state();

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    // chains reset to the idle pin level, so no false shutdown follows reset
    psp_pin_sync #(
        .RST_VAL(1'b1)
    ) u_guard_sync (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .pin_i(guard_pin_n_i),
        .level_o(guard_pin_n)
    );

    psp_pin_sync #(
        .RST_VAL(1'b1)
    ) u_shutdown_sync (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .pin_i(shutdown_pin_n_i),
        .level_o(shutdown_pin_n)
    );

    // ----------------------------------------------------------------
    // derived status
    // ----------------------------------------------------------------
    logic busy;
    logic guarded;
    logic shut;
    logic [8:0] status;

    // every status bit but the four reserved ones is a view of state, nothing here is writable
    always_comb begin
        busy = (q.prog == PSP_PROG);
        guarded = !guard_pin_n || q.nv_guard;
        shut = !shutdown_pin_n;
        status = {RESERVED_HIGH_BITS, busy, q.nv_lock1,
                  q.nv_lock0, shut, guarded};
    end

    // ----------------------------------------------------------------
    // address classes
    // ----------------------------------------------------------------
    logic is_volatile;
    logic is_nv;
    logic nv_locked;

    // status counts as volatile: it stays readable while a cycle runs
    always_comb begin
        is_volatile = (cmd_addr_i == ADDR_VWIPER0) || (cmd_addr_i == ADDR_VWIPER1) ||
                      (cmd_addr_i == ADDR_TERM_CONN) || (cmd_addr_i == ADDR_STATUS);
        is_nv = !is_volatile;
        nv_locked = ((cmd_addr_i == ADDR_NVWIPER0) && q.nv_lock0) ||
                    ((cmd_addr_i == ADDR_NVWIPER1) && q.nv_lock1);
    end

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    logic [8:0] rd_word;

    always_comb begin
        case (cmd_addr_i)
            ADDR_VWIPER0: rd_word = q.vol_w0;
            ADDR_VWIPER1: rd_word = q.vol_w1;
            ADDR_TERM_CONN: rd_word = {RESERVED_TERM_CONN_BIT, q.term_conn};
            ADDR_STATUS: rd_word = status;
            default: rd_word = q.nv_mem[cmd_addr_i];
        endcase
    end

    // ----------------------------------------------------------------
    // volatile wiper step
    // ----------------------------------------------------------------
    // above full scale both steps are ignored; at the ends one of them is
    // the sum can only wrap where step_ok is already low
    logic [8:0] cur_w;
    logic step_ok;
    logic [8:0] stepped_w;

    always_comb begin
        cur_w = (cmd_addr_i == ADDR_VWIPER1) ? q.vol_w1 : q.vol_w0;
        if (cmd_op_i == OP_INC) begin
            step_ok = cur_w < FULL_SCALE;
            stepped_w = cur_w + WIPER_STEP;
        end else begin
            step_ok = (cur_w != ZERO_SCALE) && (cur_w <= FULL_SCALE);
            stepped_w = cur_w - WIPER_STEP;
        end
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic lock_this;
        logic [7:0] tc;
        logic sd;
        lock_this = 1'b0;
        tc = q.term_conn;
        sd = 1'b0;
        nxt_q = q;
        nxt_q.ack = 1'b0;
        nxt_q.err = 1'b0;

        // serial commands; a refusal leaves stored words as they were, except the unlocked nibble of a connect write
        if (cmd_valid_i) begin
            nxt_q.ack = 1'b1;
            lock_this = ((cmd_addr_i == ADDR_VWIPER0) && q.nv_lock0) ||
                        ((cmd_addr_i == ADDR_VWIPER1) && q.nv_lock1);
            if (busy && is_nv) begin
                nxt_q.err = 1'b1;
            end else begin
                case (cmd_op_i)
                    OP_READ: begin
                        nxt_q.rdata = rd_word;
                    end
                    OP_WRITE: begin
                        if (cmd_addr_i == ADDR_STATUS) begin
                            nxt_q.err = 1'b1;
                        end else if (cmd_addr_i == ADDR_TERM_CONN) begin
                            // each nibble is guarded by its own channel lock
                            if (!q.nv_lock0) begin
                                tc[3:0] = cmd_data_i[3:0];
                            end
                            if (!q.nv_lock1) begin
                                tc[7:4] = cmd_data_i[7:4];
                            end
                            nxt_q.term_conn = tc;
                            nxt_q.err = q.nv_lock0 || q.nv_lock1;
                        end else if (is_volatile) begin
                            if (lock_this) begin
                                nxt_q.err = 1'b1;
                            end else if (cmd_addr_i == ADDR_VWIPER0) begin
                                nxt_q.vol_w0 = cmd_data_i;
                            end else begin
                                nxt_q.vol_w1 = cmd_data_i;
                            end
                        end else if (guarded || nv_locked) begin
                            nxt_q.err = 1'b1;
                        end else begin
                            // the word lands when the programming time ends
                            nxt_q.prog = PSP_PROG;
                            nxt_q.cnt = '0;
                            nxt_q.pend_hv = 1'b0;
                            nxt_q.pend_addr = cmd_addr_i;
                            nxt_q.pend_data = cmd_data_i;
                        end
                    end
                    OP_INC, OP_DEC: begin
                        if (!((cmd_addr_i == ADDR_VWIPER0) ||
                              (cmd_addr_i == ADDR_VWIPER1)) || lock_this || !step_ok) begin
                            nxt_q.err = 1'b1;
                        end else if (cmd_addr_i == ADDR_VWIPER0) begin
                            nxt_q.vol_w0 = stepped_w;
                        end else begin
                            nxt_q.vol_w1 = stepped_w;
                        end
                    end
                    default: begin
                        nxt_q.err = 1'b1;
                    end
                endcase
            end
        end else if (hv_valid_i) begin
            // hidden bits move only here, never on an ordinary write
            nxt_q.ack = 1'b1;
            if (busy || (hv_sel_i > HV_LOCK1)) begin
                nxt_q.err = 1'b1;
            end else begin
                nxt_q.prog = PSP_PROG;
                nxt_q.cnt = '0;
                nxt_q.pend_hv = 1'b1;
                nxt_q.pend_sel = hv_sel_i;
                nxt_q.pend_set = hv_set_i;
            end
        end

        // programming cycle; the result is visible only once it finishes
        // busy refuses any new start, so the counter has one owner here
        case (q.prog)
            PSP_IDLE: begin
            end
            PSP_PROG: begin
                nxt_q.cnt = q.cnt + CNT_W'(1);
                if (q.cnt == EE_LAST) begin
                    nxt_q.prog = PSP_IDLE;
                    if (!q.pend_hv) begin
                        nxt_q.nv_mem[q.pend_addr] = q.pend_data;
                    end else if (q.pend_sel == HV_GUARD) begin
                        nxt_q.nv_guard = q.pend_set;
                    end else if (q.pend_sel == HV_LOCK0) begin
                        nxt_q.nv_lock0 = q.pend_set;
                    end else begin
                        nxt_q.nv_lock1 = q.pend_set;
                    end
                end
            end
            default: begin
                nxt_q.prog = PSP_IDLE;
            end
        endcase

        // staged value reaches the terminals at command end
        if (cmd_done_i) begin
            nxt_q.term_conn_live = q.term_conn;
        end

        // terminal drive per channel; the pin never touches stored bits
        for (int c = 0; c < 2; c++) begin
            sd = shut || !q.term_conn_live[c*TC_CHAN_W+TC_OVERRIDE];
            nxt_q.term_a_en[c] = !sd && q.term_conn_live[c*TC_CHAN_W+TC_TERM_A];
            nxt_q.term_w_en[c] = sd || q.term_conn_live[c*TC_CHAN_W+TC_WIPER];
            nxt_q.term_b_en[c] = sd || q.term_conn_live[c*TC_CHAN_W+TC_TERM_B];
            nxt_q.wiper_to_b[c] = sd;
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q <= RST_STATE;
        end else begin
            q <= nxt_q;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // words come from flops; status and the busy output are live views of state
    assign ack_o = q.ack;
    assign err_o = q.err;
    assign rdata_o = q.rdata;
    assign eeprom_write_active_o = busy;
    assign status_o = status;
    assign wiper0_o = q.vol_w0;
    assign wiper1_o = q.vol_w1;
    assign term_a_en_o = q.term_a_en;
    assign term_w_en_o = q.term_w_en;
    assign term_b_en_o = q.term_b_en;
    assign wiper_to_b_o = q.wiper_to_b;

endmodule : psp_protect_status

`default_nettype wire

//--- dv/psp_protect_status_checker.sv
// port checker for the protection and status block
`default_nettype none
module psp_protect_status_checker
    import psp_pkg::*;
#(
    parameter int unsigned EE_CYCLES = 8
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic cmd_valid_i,
    input wire logic [1:0] cmd_op_i,
    input wire logic [3:0] cmd_addr_i,
    input wire logic cmd_done_i,
    input wire logic ack_o,
    input wire logic err_o,
    input wire logic eeprom_write_active_o,
    input wire logic [8:0] status_o,
    input wire logic [8:0] wiper0_o,
    input wire logic [8:0] wiper1_o,
    input wire logic [1:0] term_a_en_o,
    input wire logic [1:0] wiper_to_b_o
);
    // ----------------------------------------------------------------
    // assertions on the single clock
    // ----------------------------------------------------------------
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    wire logic wr_take = cmd_valid_i && cmd_op_i == OP_WRITE;
    // neither shutdown nor a frame close: the only two causes of a terminal move
    wire logic quiet = !status_o[1] && !cmd_done_i;
    a_rsvd_ones: assert property (status_o[8:5] == 4'hF)
        else $error("reserved status bits not all one");
    a_busy_mirror: assert property (status_o[4] == eeprom_write_active_o)
        else $error("status busy bit differs from busy output");
    a_busy_refuse: assert property (
        cmd_valid_i && eeprom_write_active_o && !(cmd_addr_i inside {4'h0, 4'h1, 4'h4, 4'h5})
        |=> ack_o && err_o) else $error("command accepted during eeprom cycle");
    a_busy_start: assert property (
        wr_take && !eeprom_write_active_o && !status_o[0] && cmd_addr_i >= ADDR_GP_FIRST
        |=> ack_o && !err_o && eeprom_write_active_o) else $error("open eeprom write not started");
    a_guard_block: assert property (
        wr_take && !eeprom_write_active_o && status_o[0] && cmd_addr_i >= ADDR_GP_FIRST
        |=> err_o && !eeprom_write_active_o) else $error("guarded eeprom write started");
    a_status_ro: assert property (wr_take && cmd_addr_i == ADDR_STATUS |=> err_o)
        else $error("status word write accepted");
    a_lock0_wiper: assert property (
        wr_take && status_o[2] && cmd_addr_i == ADDR_VWIPER0 |=> err_o && $stable(wiper0_o))
        else $error("locked wiper 0 written");
    a_lock1_wiper: assert property (
        wr_take && status_o[3] && cmd_addr_i == ADDR_VWIPER1 |=> err_o && $stable(wiper1_o))
        else $error("locked wiper 1 written");
    a_lock_hidden: assert property (
        $changed(status_o[3:2]) |-> $fell(eeprom_write_active_o))
        else $error("lock bit moved outside a programming cycle");
    a_shutdown_term: assert property (
        status_o[1] && $past(status_o[1]) |-> term_a_en_o == 2'b00 && wiper_to_b_o == 2'b11)
        else $error("shutdown terminal configuration missing");
    a_term_hold: assert property (
        !status_o[1] && $past(quiet) && $past(quiet, 2) |-> $stable(term_a_en_o))
        else $error("terminal moved without frame close");
endmodule : psp_protect_status_checker

bind psp_protect_status psp_protect_status_checker #(.EE_CYCLES(EE_CYCLES)) psp_chk_inst (.*);
`default_nettype wire

//--- dv/psp_host_model.sv
// host model: issues serial and high-voltage commands one frame at a time
`default_nettype none
module psp_host_model
    import psp_pkg::*;
(
    input wire logic mclk_i,
    input wire logic ack_i,
    input wire logic err_i,
    input wire logic [8:0] rdata_i,
    output logic cmd_valid_o,
    output logic [1:0] cmd_op_o,
    output logic [3:0] cmd_addr_o,
    output logic [8:0] cmd_data_o,
    output logic cmd_done_o,
    output logic hv_valid_o,
    output logic [1:0] hv_sel_o,
    output logic hv_set_o
);
    // ----------------------------------------------------------------
    // frame driver
    // ----------------------------------------------------------------
    initial begin
        {cmd_valid_o, cmd_done_o, hv_valid_o} = 3'h0;
        {cmd_op_o, cmd_addr_o, cmd_data_o, hv_sel_o, hv_set_o} = 18'h0;
    end
    // one-cycle request, answer taken next cycle, then the frame closes
    task automatic xfer(input bit hv, input logic [1:0] op, input logic [3:0] a,
        input logic [8:0] d, output logic ack, output logic err, output logic [8:0] rd);
        @(posedge mclk_i);
        #1;
        cmd_valid_o = !hv;
        hv_valid_o = hv;
        {cmd_op_o, hv_sel_o, cmd_addr_o, cmd_data_o, hv_set_o} = {op, op, a, d, d[0]};
        @(posedge mclk_i);
        #1;
        {cmd_valid_o, hv_valid_o, cmd_done_o} = 3'b001;
        // released lines carry the inverse so a stale value never looks live
        {cmd_op_o, hv_sel_o, cmd_addr_o, cmd_data_o, hv_set_o} = ~{op, op, a, d, d[0]};
        {ack, err, rd} = {ack_i, err_i, rdata_i};
        @(posedge mclk_i);
        #1;
        cmd_done_o = 1'b0;
    endtask : xfer
endmodule : psp_host_model
`default_nettype wire

//--- dv/tb_top.sv
// self-checking bench for the protection and status block
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
    $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import psp_pkg::*;
    localparam int EE = 8;
    logic mclk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic guard_pin_n_i = 1'b1;
    logic shutdown_pin_n_i = 1'b1;
    logic cmd_valid_i, cmd_done_i, hv_valid_i, hv_set_i, ack_o, err_o, eeprom_write_active_o;
    logic [1:0] cmd_op_i, hv_sel_i, term_a_en_o, term_w_en_o, term_b_en_o, wiper_to_b_o, lk;
    logic [3:0] cmd_addr_i;
    logic [8:0] cmd_data_i, rdata_o, status_o, wiper0_o, wiper1_o, rd;
    logic [8:0] exp_mem [16];
    logic gp = 1'b0, sd = 1'b0, gb, bz, k, e;
    int n_fail = 0;
    int num_checks = 0;
    int cyc = 0;
    int seed = 32'h0d54;
    wire [7:0] terms = {term_a_en_o, term_w_en_o, term_b_en_o, wiper_to_b_o};
    // ----------------------------------------------------------------
    // design, host, clock and hang guard
    // ----------------------------------------------------------------
    psp_protect_status #(.RES_8BIT(1'b1), .EE_CYCLES(EE)) psp_protect_status_inst (.*);
    psp_host_model psp_host_model_inst (.mclk_i(mclk_i), .ack_i(ack_o), .err_i(err_o),
        .rdata_i(rdata_o), .cmd_valid_o(cmd_valid_i), .cmd_op_o(cmd_op_i),
        .cmd_addr_o(cmd_addr_i), .cmd_data_o(cmd_data_i), .cmd_done_o(cmd_done_i),
        .hv_valid_o(hv_valid_i), .hv_sel_o(hv_sel_i), .hv_set_o(hv_set_i));
    always #5 mclk_i = ~mclk_i;
    // the whole run needs well under a thousand cycles
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            finish_test();
        end
    end
    task automatic finish_test();
        if (n_fail == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test
    function automatic logic [8:0] stat();
        return {4'hF, bz, lk[1], lk[0], sd, gp | gb};
    endfunction : stat
    task automatic cmd(input bit hv, input logic [1:0] op, input logic [3:0] a,
        input logic [8:0] dt, input logic ee);
        psp_host_model_inst.xfer(hv, op, a, dt, k, e, rd);
        `CHK(k, 1'b1)
        `CHK(e, ee)
    endtask : cmd
    task automatic rd_chk(input logic [3:0] a);
        cmd(1'b0, OP_READ, a, 9'h000, 1'b0);
        `CHK(rd, (a == ADDR_STATUS) ? stat() : exp_mem[a])
    endtask : rd_chk
    task automatic idle();
        for (int i = 0; i < 40 && eeprom_write_active_o !== 1'b0; i++) begin
            @(posedge mclk_i);
            #1;
        end
        `CHK(eeprom_write_active_o, 1'b0)
        bz = 1'b0;
    endtask : idle
    task automatic pins(input logic g_n, input logic s_n);
        {guard_pin_n_i, shutdown_pin_n_i} = {g_n, s_n};
        {gp, sd} = ~{g_n, s_n};
        repeat (6) @(posedge mclk_i);
        #1;
    endtask : pins
    // a write; eeprom targets are probed while the cycle runs
    task automatic wr(input logic [3:0] a, input logic [8:0] d, input bit ok);
        cmd(1'b0, OP_WRITE, a, d, !ok);
        if (ok && (a inside {4'h2, 4'h3} || a > 4'h5)) begin
            `CHK(eeprom_write_active_o, 1'b1)
            bz = 1'b1;
            rd_chk(ADDR_STATUS);
            cmd(1'b0, OP_READ, 4'h6, 9'h000, 1'b1);
            idle();
        end
        if (ok) exp_mem[a] = (a == ADDR_TERM_CONN) ? {1'b1, d[7:0]} : d;
        rd_chk(a);
    endtask : wr
    task automatic hvc(input logic [1:0] s, input logic v);
        cmd(1'b1, s, 4'h0, {8'h00, v}, 1'b0);
        bz = 1'b1;
        rd_chk(ADDR_STATUS);
        cmd(1'b1, HV_LOCK1, 4'h0, 9'h001, 1'b1);
        idle();
        if (s == HV_GUARD) gb = v; else lk[s == HV_LOCK1] = v;
        rd_chk(ADDR_STATUS);
    endtask : hvc
    // power event: reset for 12 cycles, then the whole map against the factory image
    task automatic por();
        rstn_i = 1'b0;
        repeat (12) @(posedge mclk_i);
        #1;
        rstn_i = 1'b1;
        {lk, gb, bz} = 4'h0;
        for (int a = 0; a < 16; a++) begin
            exp_mem[a] = (a < 4) ? MID_SCALE_8BIT : ((a == 4) ? TERM_CONN_RESET : GP_FACTORY);
            rd_chk(4'(a));
        end
    endtask : por
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        por();
        wr(4'(6 + ($unsigned($random(seed)) % 10)), 9'($random(seed)), 1'b1);
        wr(ADDR_NVWIPER0, 9'h0A5, 1'b1);
        repeat (4) wr(4'($random(seed) & 1), {1'b0, 8'($random(seed))}, 1'b1);
        `CHK({wiper1_o, wiper0_o}, {exp_mem[1], exp_mem[0]})
        // guard pin blocks eeprom only
        pins(1'b0, 1'b1);
        rd_chk(ADDR_STATUS);
        wr(ADDR_NVWIPER1, 9'h011, 1'b0);
        wr(ADDR_TERM_CONN, 9'h0FF, 1'b1);
        cmd(1'b0, OP_INC, ADDR_VWIPER1, 9'h000, 1'b0);
        exp_mem[1]++;
        rd_chk(ADDR_VWIPER1);
        cmd(1'b0, OP_DEC, ADDR_VWIPER1, 9'h000, 1'b0);
        exp_mem[1]--;
        rd_chk(ADDR_VWIPER1);
        // steps past either end of the wiper range are refused
        wr(ADDR_VWIPER0, ZERO_SCALE, 1'b1);
        cmd(1'b0, OP_DEC, ADDR_VWIPER0, 9'h000, 1'b1);
        wr(ADDR_VWIPER0, FULL_SCALE_8BIT, 1'b1);
        cmd(1'b0, OP_INC, ADDR_VWIPER0, 9'h000, 1'b1);
        rd_chk(ADDR_VWIPER0);
        pins(1'b1, 1'b1);
        hvc(HV_GUARD, 1'b1);
        wr(4'hF, 9'h1C3, 1'b0);
        wr(ADDR_STATUS, 9'h000, 1'b0);
        hvc(HV_GUARD, 1'b0);
        cmd(1'b1, 2'h3, 4'h0, 9'h001, 1'b1);
        // each lock freezes its wipers and its connect nibble
        for (int c = 0; c < 2; c++) begin
            hvc(2'(c + 1), 1'b1);
            wr(4'(c), 9'h012, 1'b0);
            wr(4'(c + 2), 9'h012, 1'b0);
            cmd(1'b0, OP_INC, 4'(c), 9'h000, 1'b1);
            cmd(1'b0, OP_WRITE, ADDR_TERM_CONN, 9'h000, 1'b1);
            exp_mem[4][4 * (1 - c) +: 4] = 4'h0;
            rd_chk(ADDR_TERM_CONN);
            hvc(2'(c + 1), 1'b0);
        end
        wr(ADDR_TERM_CONN, 9'h1FF, 1'b1);
        cmd(1'b0, OP_WRITE, ADDR_TERM_CONN, 9'h0E5, 1'b0);
        exp_mem[4] = 9'h1E5;
        `CHK(terms, 8'hFC)
        @(posedge mclk_i);
        #1;
        `CHK(terms, 8'hB5)
        // shutdown pin overrides the connect bits but leaves them stored
        pins(1'b1, 1'b0);
        rd_chk(ADDR_STATUS);
        `CHK({term_a_en_o, wiper_to_b_o}, 4'h3)
        rd_chk(ADDR_TERM_CONN);
        pins(1'b1, 1'b1);
        `CHK(terms, 8'hB5)
        por();
        wr(ADDR_TERM_CONN, 9'h0E5, 1'b1);
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
